// ---- rtl/scdd_regs.vh ----
// constants for the system control and descriptor decode block
//Contract
//RULE1 - prot_enable set enables segment protection
//RULE2 - monitor_coproc and task_switched fault wait instruction
//RULE3 - emulate_coproc faults every floating point instruction
//RULE4 - task switch sets task_switched; fpu faults
//RULE5 - supervisor_wp controls write to read-only pages
//RULE6 - alignment fault needs align_mask and align_check
//RULE7 - cache_disable stops fills, hits still served
//RULE8 - paging needs paging_enable and prot_enable
//RULE9 - page fault captures linear address
//RULE10 - directory base is 4 KByte aligned
//RULE11 - any level reads, level 0 writes
//RULE12 - 16-bit global load keeps 24-bit base
//RULE13 - global table entry 0 never used
//RULE14 - local selector load caches global descriptor
//RULE15 - base and limit assembled from descriptor words
//RULE16 - granularity bit scales limit by pages
//RULE17 - bit 22 sets default operand size
//RULE18 - system descriptor types decoded
//RULE19 - application type bits decoded
//RULE20 - gate types decoded
//RULE21 - call gate parameter count copied
//RULE22 - system descriptors in global, gates in interrupt table; only interrupt and trap gates set gate_in_idt_only
//RULE23 - table_indicator picks global or local table
//RULE24 - unprivileged register writes fault, value kept
`ifndef SCDD_REGS_VH
`define SCDD_REGS_VH
`define SCDD_PE_BIT       0
`define SCDD_MP_BIT       1
`define SCDD_EM_BIT       2
`define SCDD_TS_BIT       3
`define SCDD_WP_BIT       16
`define SCDD_AM_BIT       18
`define SCDD_CD_BIT       30
`define SCDD_PG_BIT       31
`define SCDD_FLAG_AC_BIT  18
`define SCDD_CW_RESET     32'h00000010
`define SCDD_CW_FIXED1    32'h00000010
`define SCDD_CW_WMASK     32'hC005000F
`define SCDD_FAULT_NM     8'h07
`define SCDD_FAULT_GP     8'h0D
`define SCDD_FAULT_AC     8'h11
`define SCDD_FAULT_PF     8'h0E
`define SCDD_SEL_TI_BIT   2
`define SCDD_DIR_LOW_MASK 32'h00000FFF
`define SCDD_SYS_LOCAL    4'h2
`define SCDD_SYS_TSS_IDLE 4'h9
`define SCDD_SYS_TSS_BUSY 4'hB
`define SCDD_GATE_CALL16  4'h4
`define SCDD_GATE_TASK    4'h5
`define SCDD_GATE_INT16   4'h6
`define SCDD_GATE_TRAP16  4'h7
`define SCDD_GATE_CALL32  4'hC
`define SCDD_GATE_INT32   4'hE
`define SCDD_GATE_TRAP32  4'hF
`define SCDD_CLS_NONE     3'h0
`define SCDD_CLS_APP      3'h1
`define SCDD_CLS_SYS      3'h2
`define SCDD_CLS_GATE     3'h3
`define SCDD_CLS_BAD      3'h4
`define SCDD_ST_IDLE      2'h0
`define SCDD_ST_FETCH     2'h1
`define SCDD_ST_WAIT      2'h2
`endif

// ---- rtl/scdd_core.v ----
// system control registers, checks and descriptor decode
`timescale 1ns/1ps
`include "scdd_regs.vh"
module scdd_core (
  input  wire        sys_clk,
  input  wire        reset_n,
  input  wire [1:0]  cur_priv,
  input  wire        op_size32,
  input  wire [31:0] flags_word,
  input  wire        wr_ctrl,
  input  wire        wr_dirbase,
  input  wire        wr_global,
  input  wire        wr_interrupt,
  input  wire        wr_local,
  input  wire [47:0] wr_data,
  input  wire        task_switch,
  input  wire        instr_valid,
  input  wire        instr_fp,
  input  wire        instr_wait,
  input  wire        mem_valid,
  input  wire        mem_write,
  input  wire        mem_misaligned,
  input  wire        page_readonly,
  input  wire        page_miss,
  input  wire [31:0] mem_linear,
  input  wire        desc_valid,
  input  wire [31:0] desc_low,
  input  wire [31:0] desc_high,
  input  wire        gdt_rd_ack,
  input  wire [31:0] gdt_rd_low,
  input  wire [31:0] gdt_rd_high,
  input  wire [15:0] seg_selector,
  input  wire        seg_sel_valid,
  output reg  [31:0] system_control_word,
  output reg  [31:0] fault_address_reg,
  output reg  [31:0] page_directory_base,
  output reg  [47:0] global_table_locator,
  output reg  [47:0] interrupt_table_locator,
  output reg  [15:0] local_table_selector,
  output reg  [31:0] local_base,
  output reg  [31:0] local_limit,
  output reg         local_busy,
  output reg         gdt_rd_req,
  output reg  [31:0] gdt_rd_addr,
  output reg         fault_valid,
  output reg  [7:0]  fault_vector,
  output reg         protect_on,
  output reg         paging_on,
  output reg         cache_fill_en,
  output reg  [31:0] table_entry_addr,
  output reg         table_sel_null,
  output reg         table_sel_bad,
  output reg  [31:0] seg_base,
  output reg  [31:0] seg_limit,
  output reg         seg_default32,
  output reg  [2:0]  desc_class,
  output reg  [3:0]  desc_type,
  output reg         desc_present,
  output reg  [1:0]  desc_priv_level,
  output reg         app_code,
  output reg         app_expand_down,
  output reg         app_writable,
  output reg         app_conforming,
  output reg         app_readable,
  output reg         app_accessed,
  output reg         gate_is32,
  output reg         gate_in_idt_only,
  output reg  [4:0]  gate_param_count,
  output reg  [15:0] gate_selector,
  output reg  [31:0] gate_offset
);

  reg  [1:0]  state_reg;
  reg  [15:0] pend_sel_reg;
  wire        priv_ok;
  wire        any_write;
  wire        fpu_fault;
  wire        wait_fault;
  wire        align_fault;
  wire        wp_fault;
  wire        pf_fault;
  wire        gp_fault;
  wire [31:0] cw_next;

  // base from both words
  function [31:0] f_base;
    input [31:0] lo;
    input [31:0] hi;
    begin
      f_base = {hi[31:24], hi[7:0], lo[31:16]}; // [RULE15]
    end
  endfunction

  // limit, scaled by granularity
  function [31:0] f_limit;
    input [31:0] lo;
    input [31:0] hi;
    begin
      if (hi[23])
        f_limit = {hi[19:16], lo[15:0], 12'hFFF}; // [RULE16]
      else
        f_limit = {12'h000, hi[19:16], lo[15:0]}; // [RULE15]
    end
  endfunction

  assign priv_ok   = ~system_control_word[`SCDD_PE_BIT] || (cur_priv == 2'h0); // [RULE11]
  assign any_write = wr_ctrl | wr_dirbase | wr_global | wr_interrupt | wr_local;
  assign gp_fault  = any_write & ~priv_ok; // [RULE24]
  assign wait_fault = instr_valid & instr_wait & system_control_word[`SCDD_MP_BIT]
                    & system_control_word[`SCDD_TS_BIT]; // [RULE2]
  assign fpu_fault = instr_valid & instr_fp & (system_control_word[`SCDD_EM_BIT]   // [RULE3]
                   | system_control_word[`SCDD_TS_BIT]); // [RULE4]
  assign align_fault = mem_valid & mem_misaligned & system_control_word[`SCDD_AM_BIT]
                     & flags_word[`SCDD_FLAG_AC_BIT]; // [RULE6]
  assign wp_fault  = mem_valid & mem_write & page_readonly & paging_on
                   & (system_control_word[`SCDD_WP_BIT] || (cur_priv == 2'h3)); // [RULE5]
  assign pf_fault  = mem_valid & paging_on & (page_miss | wp_fault);
  assign cw_next   = (wr_data[31:0] & `SCDD_CW_WMASK) | `SCDD_CW_FIXED1;

  // control, paging and table locator registers
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      system_control_word     <= `SCDD_CW_RESET;
      fault_address_reg       <= 32'h00000000;
      page_directory_base     <= 32'h00000000;
      global_table_locator    <= 48'h000000000000;
      interrupt_table_locator <= 48'h000000000000;
      protect_on              <= 1'b0;
      paging_on               <= 1'b0;
      cache_fill_en           <= 1'b1;
      fault_valid             <= 1'b0;
      fault_vector            <= 8'h00;
    end else begin
      if (wr_ctrl && priv_ok) begin
        system_control_word <= cw_next;
        protect_on    <= cw_next[`SCDD_PE_BIT]; // [RULE1]
        paging_on     <= cw_next[`SCDD_PG_BIT] & cw_next[`SCDD_PE_BIT]; // [RULE8]
        cache_fill_en <= ~cw_next[`SCDD_CD_BIT]; // [RULE7]
      end else if (task_switch) begin
        system_control_word[`SCDD_TS_BIT] <= 1'b1; // [RULE4]
      end
      if (wr_dirbase && priv_ok)
        page_directory_base <= wr_data[31:0] & ~`SCDD_DIR_LOW_MASK; // [RULE10]
      if (wr_global && priv_ok) begin
        if (op_size32)
          global_table_locator <= wr_data;
        else
          global_table_locator <= {8'h00, wr_data[39:0]}; // [RULE12]
      end
      if (wr_interrupt && priv_ok)
        interrupt_table_locator <= wr_data;
      if (pf_fault)
        fault_address_reg <= mem_linear; // [RULE9]
      fault_valid <= gp_fault | wait_fault | fpu_fault | align_fault | pf_fault;
      if (gp_fault)
        fault_vector <= `SCDD_FAULT_GP; // [RULE24]
      else if (wait_fault || fpu_fault)
        fault_vector <= `SCDD_FAULT_NM; // [RULE2]
      else if (pf_fault)
        fault_vector <= `SCDD_FAULT_PF;
      else if (align_fault)
        fault_vector <= `SCDD_FAULT_AC;
    end
  end

  // local selector load and hidden descriptor fetch
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg            <= `SCDD_ST_IDLE;
      pend_sel_reg         <= 16'h0000;
      local_table_selector <= 16'h0000;
      local_base           <= 32'h00000000;
      local_limit          <= 32'h00000000;
      local_busy           <= 1'b0;
      gdt_rd_req           <= 1'b0;
      gdt_rd_addr          <= 32'h00000000;
    end else begin
      case (state_reg)
        `SCDD_ST_IDLE: begin
          gdt_rd_req <= 1'b0;
          if (wr_local && priv_ok) begin
            local_table_selector <= wr_data[15:0];
            pend_sel_reg         <= wr_data[15:0];
            if (wr_data[15:3] == 13'h0000) begin
              local_base  <= 32'h00000000; // [RULE13]
              local_limit <= 32'h00000000;
            end else begin
              local_busy <= 1'b1;
              state_reg  <= `SCDD_ST_FETCH;
            end
          end
        end
        `SCDD_ST_FETCH: begin
          gdt_rd_req  <= 1'b1; // [RULE22]
          gdt_rd_addr <= global_table_locator[47:16]
                       + {16'h0000, pend_sel_reg[15:3], 3'h0}; // [RULE14]
          state_reg   <= `SCDD_ST_WAIT;
        end
        `SCDD_ST_WAIT: begin
          if (gdt_rd_ack) begin
            gdt_rd_req  <= 1'b0;
            local_base  <= f_base(gdt_rd_low, gdt_rd_high); // [RULE14]
            local_limit <= f_limit(gdt_rd_low, gdt_rd_high);
            local_busy  <= 1'b0;
            state_reg   <= `SCDD_ST_IDLE;
          end
        end
        default: begin
          state_reg  <= `SCDD_ST_IDLE;
          gdt_rd_req <= 1'b0;
          local_busy <= 1'b0;
        end
      endcase
    end
  end

  // selector to table entry address
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      table_entry_addr <= 32'h00000000;
      table_sel_null   <= 1'b0;
      table_sel_bad    <= 1'b0;
    end else if (seg_sel_valid) begin
      if (seg_selector[`SCDD_SEL_TI_BIT]) begin
        table_entry_addr <= local_base + {16'h0000, seg_selector[15:3], 3'h0}; // [RULE23]
        table_sel_null   <= 1'b0;
        table_sel_bad    <= ({16'h0000, seg_selector[15:3], 3'h7} > local_limit);
      end else begin
        table_entry_addr <= global_table_locator[47:16]
                          + {16'h0000, seg_selector[15:3], 3'h0}; // [RULE23]
        table_sel_null   <= (seg_selector[15:3] == 13'h0000); // [RULE13]
        table_sel_bad    <= ({seg_selector[15:3], 3'h7} > global_table_locator[15:0]);
      end
    end
  end

  // descriptor decode
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      seg_base         <= 32'h00000000;
      seg_limit        <= 32'h00000000;
      seg_default32    <= 1'b0;
      desc_class       <= `SCDD_CLS_NONE;
      desc_type        <= 4'h0;
      desc_present     <= 1'b0;
      desc_priv_level  <= 2'h0;
      app_code         <= 1'b0;
      app_expand_down  <= 1'b0;
      app_writable     <= 1'b0;
      app_conforming   <= 1'b0;
      app_readable     <= 1'b0;
      app_accessed     <= 1'b0;
      gate_is32        <= 1'b0;
      gate_in_idt_only <= 1'b0;
      gate_param_count <= 5'h00;
      gate_selector    <= 16'h0000;
      gate_offset      <= 32'h00000000;
    end else if (desc_valid) begin
      seg_base        <= f_base(desc_low, desc_high); // [RULE15]
      seg_limit       <= f_limit(desc_low, desc_high); // [RULE16]
      seg_default32   <= desc_high[22]; // [RULE17]
      desc_type       <= desc_high[11:8];
      desc_present    <= desc_high[15];
      desc_priv_level <= desc_high[14:13];
      app_code        <= desc_high[12] & desc_high[11]; // [RULE19]
      app_expand_down <= desc_high[12] & ~desc_high[11] & desc_high[10];
      app_writable    <= desc_high[12] & ~desc_high[11] & desc_high[9];
      app_conforming  <= desc_high[12] & desc_high[11] & desc_high[10];
      app_readable    <= desc_high[12] & desc_high[11] & desc_high[9];
      app_accessed    <= desc_high[12] & desc_high[8];
      gate_is32       <= desc_high[11]; // [RULE20]
      gate_param_count <= desc_high[4:0]; // [RULE21]
      gate_selector   <= desc_low[31:16];
      gate_offset     <= {desc_high[31:16], desc_low[15:0]};
      gate_in_idt_only <= 1'b0;
      if (desc_high[12]) begin
        desc_class <= `SCDD_CLS_APP;
      end else begin
        case (desc_high[11:8])
          `SCDD_SYS_LOCAL, `SCDD_SYS_TSS_IDLE, `SCDD_SYS_TSS_BUSY: begin
            desc_class <= `SCDD_CLS_SYS; // [RULE18]
          end
          `SCDD_GATE_CALL16, `SCDD_GATE_TASK, `SCDD_GATE_CALL32: begin
            desc_class <= `SCDD_CLS_GATE; // [RULE20]
          end
          `SCDD_GATE_INT16, `SCDD_GATE_TRAP16, `SCDD_GATE_INT32, `SCDD_GATE_TRAP32: begin
            desc_class       <= `SCDD_CLS_GATE;
            gate_in_idt_only <= 1'b1; // [RULE22]
          end
          default: begin
            desc_class <= `SCDD_CLS_BAD;
          end
        endcase
      end
    end
  end

endmodule // scdd_core

// ---- verif/scdd_gdt_model.sv ----
// global table memory model answering local descriptor fetches
`timescale 1ns/1ps
module scdd_gdt_model (
  input  wire        sys_clk,
  input  wire        reset_n,
  input  wire        gdt_rd_req,
  input  wire [31:0] gdt_rd_addr,
  input  wire [3:0]  lat,
  output reg         gdt_rd_ack,
  output reg  [31:0] gdt_rd_low,
  output reg  [31:0] gdt_rd_high
);
  reg [3:0] cnt;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gdt_rd_ack  <= 1'b0;
      cnt         <= 4'h0;
      gdt_rd_low  <= 32'h0;
      gdt_rd_high <= 32'h0;
    end else if (!gdt_rd_ack && gdt_rd_req && cnt == lat) begin
      gdt_rd_ack  <= 1'b1;
      gdt_rd_low  <= {gdt_rd_addr[15:0], ~gdt_rd_addr[15:0]};
      gdt_rd_high <= 32'h12038234;
    end else begin
      gdt_rd_ack  <= 1'b0;
      cnt         <= (gdt_rd_req && !gdt_rd_ack) ? cnt + 4'h1 : 4'h0;
      gdt_rd_low  <= ~gdt_rd_low;
      gdt_rd_high <= ~gdt_rd_high;
    end
  end
endmodule // scdd_gdt_model

// ---- verif/scdd_core_sva.sv ----
// assertions on the control and descriptor decode block
`timescale 1ns/1ps
`include "scdd_regs.vh"
module scdd_core_sva (
  input wire        sys_clk, reset_n, wr_ctrl, wr_dirbase, wr_global, wr_interrupt, wr_local,
  input wire        task_switch, instr_valid, instr_fp, instr_wait, mem_valid, mem_write,
  input wire        mem_misaligned, page_miss, desc_valid, fault_valid, paging_on, protect_on,
  input wire        cache_fill_en, local_busy, gdt_rd_req,
  input wire [1:0]  cur_priv,
  input wire [7:0]  fault_vector,
  input wire [31:0] flags_word, desc_low, desc_high, system_control_word, gdt_rd_addr, seg_base,
  input wire [47:0] wr_data, global_table_locator
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire [31:0] cw    = system_control_word;
  wire        ok    = !cw[0] || cur_priv == 2'h0;
  wire        nowr  = !(wr_ctrl | wr_dirbase | wr_global | wr_interrupt | wr_local);
  wire        quiet = nowr && !instr_valid;
  ctrl_write_a: assert property (
    wr_ctrl && ok |=> cw == ($past(wr_data[31:0]) & `SCDD_CW_WMASK | `SCDD_CW_FIXED1))
    else $error("control word write not applied");
  priv_block_a: assert property (
    wr_ctrl && !ok && !task_switch |=> fault_valid && fault_vector == `SCDD_FAULT_GP && $stable(cw))
    else $error("unprivileged control write not refused");
  fp_emul_a: assert property (
    instr_valid && instr_fp && cw[2] && nowr |=> fault_valid && fault_vector == `SCDD_FAULT_NM)
    else $error("emulated float instruction did not fault");
  wait_monitor_a: assert property (
    instr_valid && instr_wait && !instr_fp && cw[1] && cw[3] && nowr
      |=> fault_valid && fault_vector == `SCDD_FAULT_NM)
    else $error("monitored wait did not fault");
  mode_level_a: assert property (
    $stable(cw) |-> paging_on == (cw[31] && cw[0]) && protect_on == cw[0]
      && cache_fill_en == !cw[30])
    else $error("mode outputs disagree with control word");
  align_fault_a: assert property (
    mem_valid && mem_misaligned && !mem_write && !page_miss && quiet && cw[18] && flags_word[18]
      |=> fault_valid && fault_vector == `SCDD_FAULT_AC)
    else $error("enabled misaligned access did not fault");
  desc_base_a: assert property (
    desc_valid && desc_high[12]
      |=> seg_base == {$past(desc_high[31:24]), $past(desc_high[7:0]), $past(desc_low[31:16])})
    else $error("segment base assembled wrongly");
  local_fetch_a: assert property (
    wr_local && ok && !local_busy && !wr_global && wr_data[15:3] != 13'h0 && !wr_data[2]
      |-> ##2 gdt_rd_req && gdt_rd_addr ==
        $past(global_table_locator[47:16], 2) + {$past(wr_data[15:3], 2), 3'h0})
    else $error("local descriptor fetch address wrong");
endmodule // scdd_core_sva
bind scdd_core scdd_core_sva scdd_core_sva_inst (.*);

// ---- verif/testbench.sv ----
// self-checking bench for the control and descriptor decode block
`timescale 1ns/1ps
`include "scdd_regs.vh"
module testbench;
  reg sys_clk = 0, reset_n = 0, op_size32 = 1, wr_ctrl = 0, wr_dirbase = 0, wr_global = 0;
  reg wr_interrupt = 0, wr_local = 0, task_switch = 0, instr_valid = 0, instr_fp = 0;
  reg instr_wait = 0, mem_valid = 0, mem_write = 0, mem_misaligned = 0, page_readonly = 0;
  reg page_miss = 0, desc_valid = 0, seg_sel_valid = 0;
  reg [1:0] cur_priv = 0;
  reg [3:0] lat = 0;
  reg [15:0] seg_selector = 0;
  reg [31:0] flags_word = 0, mem_linear = 0, desc_low = 0, desc_high = 0, v, a;
  reg [47:0] wr_data = 0;
  integer err_total = 0, samples_checked = 0, i, n, t;
  wire gdt_rd_ack, local_busy, gdt_rd_req, fault_valid, protect_on, paging_on, cache_fill_en;
  wire table_sel_null, table_sel_bad, seg_default32, desc_present, app_code, app_expand_down;
  wire app_writable, app_conforming, app_readable, app_accessed, gate_is32, gate_in_idt_only;
  wire [1:0] desc_priv_level;
  wire [2:0] desc_class;
  wire [3:0] desc_type;
  wire [4:0] gate_param_count;
  wire [7:0] fault_vector;
  wire [15:0] local_table_selector, gate_selector;
  wire [31:0] gdt_rd_low, gdt_rd_high, system_control_word, fault_address_reg, gdt_rd_addr;
  wire [31:0] page_directory_base, local_base, local_limit, table_entry_addr, seg_base;
  wire [31:0] seg_limit, gate_offset;
  wire [47:0] global_table_locator, interrupt_table_locator;
  scdd_core scdd_core_inst (.*);
  scdd_gdt_model scdd_gdt_model_inst (.*);
  always #2.5 sys_clk = ~sys_clk;
  task chk(input [63:0] nm, input [47:0] e, input [47:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (e !== g) begin
        err_total = err_total + 1;
        $display("unexpected %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task go;
    begin
      @(posedge sys_clk);
      {wr_ctrl, wr_dirbase, wr_global, wr_interrupt, wr_local, task_switch} <= 6'h0;
      {instr_valid, mem_valid, desc_valid, seg_sel_valid} <= 4'h0;
      #1;
    end
  endtask
  task w(input [2:0] k, input [1:0] p, input [47:0] d);
    begin
      @(posedge sys_clk);
      cur_priv <= p;
      wr_data <= d;
      {wr_ctrl, wr_dirbase, wr_global, wr_interrupt, wr_local} <= 5'h10 >> k;
      go;
    end
  endtask
  task mem(input [1:0] p, input [3:0] f, input [31:0] l);
    begin
      @(posedge sys_clk);
      cur_priv <= p;
      mem_linear <= l;
      {mem_valid, mem_write, mem_misaligned, page_readonly, page_miss} <= {1'b1, f};
      go;
    end
  endtask
  task ins(input f, input s);
    begin
      @(posedge sys_clk);
      {instr_valid, instr_fp, instr_wait} <= {1'b1, f, s};
      go;
    end
  endtask
  task dsc(input [31:0] lo, input [31:0] hi);
    begin
      @(posedge sys_clk);
      {desc_valid, desc_low, desc_high} <= {1'b1, lo, hi};
      go;
    end
  endtask
  task sel(input [15:0] s);
    begin
      @(posedge sys_clk);
      {seg_sel_valid, seg_selector} <= {1'b1, s};
      go;
    end
  endtask
  task flt(input e, input [7:0] c);
    begin
      chk("fault", e, fault_valid);
      if (e) chk("vector", c, fault_vector);
    end
  endtask
  function [2:0] cls(input [31:0] h);
    begin
      if (h[12]) cls = `SCDD_CLS_APP;
      else case (h[11:8])
        4'h2, 4'h9, 4'hB: cls = `SCDD_CLS_SYS;
        4'h4, 4'h5, 4'h6, 4'h7, 4'hC, 4'hE, 4'hF: cls = `SCDD_CLS_GATE;
        default: cls = `SCDD_CLS_BAD;
      endcase
    end
  endfunction
  initial begin
    v = $urandom(32'hA0A3);
    repeat (12) @(posedge sys_clk);
    reset_n <= 1;
    #1;
    chk("ctrl", `SCDD_CW_RESET, system_control_word);
    for (i = 0; i < 16; i = i + 1) begin
      v = i ? $urandom : 32'h80000000;
      w(0, 0, v);
      go;
      chk("ctrl", v & `SCDD_CW_WMASK | `SCDD_CW_FIXED1, system_control_word);
      chk("prot", v[0], protect_on);
      chk("paging", v[31] & v[0], paging_on);
      chk("fill", !v[30], cache_fill_en);
    end
    w(0, 0, 48'h1);
    w(0, 3, 48'hC0050009);
    flt(1, `SCDD_FAULT_GP);
    chk("ctrl", 32'h11, system_control_word);
    for (i = 0; i < 8; i = i + 1) begin
      w(0, 0, i * 2 + 1);
      ins(1, 0);
      flt(i[1] | i[2], `SCDD_FAULT_NM);
      ins(0, 1);
      flt(i[0] & i[2], `SCDD_FAULT_NM);
    end
    w(0, 0, 48'h1);
    @(posedge sys_clk);
    task_switch <= 1;
    go;
    chk("switched", 1, system_control_word[3]);
    for (i = 0; i < 4; i = i + 1) begin
      w(0, 0, {i[0], 18'h0});
      flags_word <= {i[1], 18'h0};
      mem(0, 4'h4, $urandom);
      flt(i[0] & i[1], `SCDD_FAULT_AC);
    end
    flags_word <= 0;
    for (i = 0; i < 4; i = i + 1) begin
      w(0, 0, {i[0], 16'h0} | 32'h80000001);
      go;
      mem(i[1] ? 3 : 2, 4'hA, $urandom);
      flt(i[0] | i[1], `SCDD_FAULT_PF);
    end
    v = $urandom;
    mem(0, 4'h1, v);
    flt(1, `SCDD_FAULT_PF);
    chk("address", v, fault_address_reg);
    w(1, 0, v & 32'hFFFFF000);
    chk("dirbase", v & 32'hFFFFF000, page_directory_base);
    op_size32 <= 0;
    w(2, 0, {v, 16'h7FF8});
    chk("global", {8'h0, v[23:0], 16'h7FF8}, global_table_locator);
    op_size32 <= 1;
    w(3, 0, {~v, 16'h07FF});
    chk("intr", {~v, 16'h07FF}, interrupt_table_locator);
    w(2, 0, {v, 16'hFFFF});
    for (i = 0; i < 2; i = i + 1) begin
      lat <= i * 6;
      n = $urandom % 8191 + 1;
      a = v + n * 8;
      w(4, 0, n * 8);
      for (t = 0; t < 40 && local_busy !== 1'b0; t = t + 1) begin
        @(posedge sys_clk);
        #1;
      end
      if (t == 40) begin
        chk("busy", 0, local_busy);
        conclude;
      end
      chk("ldtsel", n * 8, local_table_selector);
      chk("ldtbase", {16'h1234, a[15:0]}, local_base);
      chk("ldtlim", {16'h3, ~a[15:0]}, local_limit);
    end
    n = $urandom % 8191 + 1;
    sel(16'h0);
    chk("null", 1, table_sel_null);
    sel({n[12:0], 3'h3});
    a = v + n * 8;
    chk("entry", a, table_entry_addr);
    chk("bad", 0, table_sel_bad);
    sel({n[12:0], 3'h4});
    a = local_base + n * 8;
    chk("entry", a, table_entry_addr);
    for (i = 0; i < 40; i = i + 1) begin
      a = $urandom;
      v = $urandom;
      v[12:8] = i[4:0];
      dsc(a, v);
      chk("class", cls(v), desc_class);
      chk("dfields", {v[11:8], v[15], v[14:13]}, {desc_type, desc_present, desc_priv_level});
      if (cls(v) == `SCDD_CLS_GATE) begin
        chk("params", v[4:0], gate_param_count);
        chk("idtonly", v[10:9] == 2'h3, gate_in_idt_only);
        chk("gate32", v[11], gate_is32);
        chk("target", {a[31:16], v[31:16], a[15:0]}, {gate_selector, gate_offset});
      end else if (cls(v) != `SCDD_CLS_BAD) begin
        chk("base", {v[31:24], v[7:0], a[31:16]}, seg_base);
        chk("limit", v[23] ? {v[19:16], a[15:0], 12'hFFF} : {v[19:16], a[15:0]}, seg_limit);
      end
      if (v[12]) chk("appbits", {v[11], !v[11] & v[10], !v[11] & v[9], v[11] & v[10],
        v[11] & v[9], v[8]}, {app_code, app_expand_down, app_writable, app_conforming,
        app_readable, app_accessed});
      if (v[12] & v[11]) chk("default", v[22], seg_default32);
    end
    for (i = 0; i < 400; i = i + 1) begin
      @(posedge sys_clk);
      v = $urandom;
      {cur_priv, op_size32} <= v[2:0];
      wr_data <= {$urandom, v[31:16]};
      {wr_ctrl, wr_global, wr_interrupt, wr_local, task_switch} <= v[7:3] & v[12:8] & v[17:13];
      {instr_valid, instr_fp, instr_wait, mem_valid, mem_write} <= v[22:18];
      {mem_misaligned, page_readonly, page_miss, desc_valid, seg_sel_valid} <= v[27:23];
      {desc_low, desc_high, mem_linear} <= {$urandom, $urandom, $urandom};
      {seg_selector, flags_word} <= {v[31:16], $urandom};
    end
    go;
    conclude;
  end
endmodule // testbench
